//--- verilog/hfr_defines.vh
// Shared constants of the hierarchical frame reconstruction block
`ifndef HFR_DEFINES_VH
`define HFR_DEFINES_VH
`define HFR_SW        16
`define HFR_MK_W      3
`define HFR_MK_SOI    3'h0
`define HFR_MK_DESC   3'h1
`define HFR_MK_EXPAND 3'h2
`define HFR_MK_SOF    3'h3
`define HFR_MK_END    3'h4
`define HFR_MK_OTHER  3'h5
`define HFR_CAT_BASE  4'he
`define HFR_CAT_DIFF  4'hf
`define HFR_ERR_W     4
`define HFR_ERR_ORDER 0
`define HFR_ERR_TWICE 1
`define HFR_ERR_FIRST 2
`define HFR_ERR_MODE  3
`endif

//--- verilog/hfr_top.v
// Marker sequencing, bilinear upsampler and modulo reconstruction
`timescale 1ns/1ns
`include "hfr_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// (R1) Descriptor segment precedes first frame
// (R2) First frame per component non-differential
// (R3) Expansion segment precedes upsampled differential frame
// (R4) At most one expansion segment per frame
// (R5) Encoder differences wrap modulo 2^16
// (R6) DCT sequence: only final frame lossless
// (R7) Lossless first frame: all later lossless
// (R8) Upsample by two, bilinear, per direction
// (R9) Interpolated sample is truncated half sum
// (R10) Left column and top line copied
// (R11) Right column, bottom line replicated
// (R12) Each pass doubles length or count
// (R13) Horizontal expansion before vertical
// (R14) Differential DCT: no shift, direct DC
// (R15) Lossless differential: no prediction, selector zero
// (R16) Differential AC adds magnitude category 15
// (R17) Parse markers until frame or end
// (R18) Early descriptor sets hierarchical path flag
// (R19) Upsample reference as expansion segment says
// (R20) Reconstruct modulo 2^16, keep as reference
// (R21) Decoder differential DCT: no shift, direct DC
// (R22) Reconstructions kept for later references
// (R23) Lossless differential: direct, point transform
// (R24) Flags cleared at reset and image start
module hfr_top #(
	parameter MAX_W = 64,
	parameter LAW   = 7,
	parameter NC    = 4,
	parameter CW    = 2
) (
	input  wire                 clock,
	input  wire                 rst,
	input  wire                 enc_mode,
	input  wire                 mk_valid,
	input  wire [`HFR_MK_W-1:0] mk_type,
	input  wire [CW-1:0]        mk_comp,
	input  wire                 mk_diff,
	input  wire                 mk_dct,
	input  wire                 mk_h,
	input  wire                 mk_v,
	input  wire [3:0]           mk_pt,
	input  wire                 frame_done,
	input  wire                 in_valid,
	input  wire [`HFR_SW-1:0]   in_data,
	input  wire                 in_last_col,
	input  wire                 in_last_row,
	output wire                 in_ready,
	input  wire                 op_valid,
	input  wire [`HFR_SW-1:0]   op_data,
	output wire                 op_ready,
	output wire                 out_valid,
	output wire [`HFR_SW-1:0]   out_data,
	input  wire                 out_ready,
	output wire                 hier_path,
	output wire                 in_frame,
	output wire                 diff_frame,
	output wire                 level_shift_en,
	output wire                 dc_pred_en,
	output wire                 pred_sel_zero,
	output wire                 pt_apply,
	output wire [3:0]           ac_cat_max,
	output wire                 up_h,
	output wire                 up_v,
	output wire                 expand_emit,
	output wire [`HFR_ERR_W-1:0] err
);

localparam ST_IDLE  = 2'h0;
localparam ST_PARSE = 2'h1;
localparam ST_FRAME = 2'h2;
localparam VS_FIRST  = 2'h0;
localparam VS_INTERP = 2'h1;
localparam VS_REPLAY = 2'h2;
localparam VS_DUP    = 2'h3;

reg  [1:0]            st_ff;
reg                   in_frame_ff;
reg                   hier_ff;
reg                   sof_seen_ff;
reg                   xpd_seen_ff;
reg                   xpd_h_ff;
reg                   xpd_v_ff;
reg                   up_h_ff;
reg                   up_v_ff;
reg                   diff_ff;
reg                   dct_ff;
reg  [3:0]            pt_ff;
reg                   first_set_ff;
reg                   first_ll_ff;
reg  [NC-1:0]         nd_done_ff;
reg  [NC-1:0]         ll_done_ff;
reg                   lvl_ff;
reg                   dcp_ff;
reg                   psz_ff;
reg                   pta_ff;
reg  [3:0]            cat_ff;
reg                   xpd_emit_ff;
reg  [`HFR_ERR_W-1:0] err_ff;

wire is_soi = mk_valid && (mk_type == `HFR_MK_SOI);
wire clr    = rst | is_soi;

////////////////////////////////////////////////////////////////////////////////
// Marker sequencing and frame mode
always @(posedge clock) begin
	if (clr) begin
		st_ff        <= rst ? ST_IDLE : ST_PARSE;
		in_frame_ff  <= 1'b0;
		hier_ff      <= 1'b0; // R24
		sof_seen_ff  <= 1'b0;
		xpd_seen_ff  <= 1'b0; // R24
		xpd_h_ff     <= 1'b0;
		xpd_v_ff     <= 1'b0;
		up_h_ff      <= 1'b0;
		up_v_ff      <= 1'b0;
		diff_ff      <= 1'b0;
		dct_ff       <= 1'b0;
		pt_ff        <= 4'h0;
		first_set_ff <= 1'b0;
		first_ll_ff  <= 1'b0;
		nd_done_ff   <= {NC{1'b0}};
		ll_done_ff   <= {NC{1'b0}};
		lvl_ff       <= 1'b0;
		dcp_ff       <= 1'b0;
		psz_ff       <= 1'b0;
		pta_ff       <= 1'b0;
		cat_ff       <= `HFR_CAT_BASE;
		xpd_emit_ff  <= 1'b0;
		err_ff       <= {`HFR_ERR_W{1'b0}};
	end else begin
		xpd_emit_ff <= 1'b0;
		if (frame_done && st_ff == ST_FRAME) begin
			st_ff   <= ST_PARSE;
			in_frame_ff <= 1'b0;
			up_h_ff <= 1'b0;
			up_v_ff <= 1'b0;
		end
		// Markers other than the image start are interpreted only in the parse state; those inside a frame or after the end marker are ignored
		if (mk_valid && st_ff == ST_PARSE) begin // R17
			case (mk_type)
			`HFR_MK_DESC: begin
				if (sof_seen_ff)
					err_ff[`HFR_ERR_ORDER] <= 1'b1; // R1
				else
					hier_ff <= 1'b1; // R18
			end
			`HFR_MK_EXPAND: begin
				if (xpd_seen_ff)
					err_ff[`HFR_ERR_TWICE] <= 1'b1; // R4
				if (!hier_ff)
					err_ff[`HFR_ERR_ORDER] <= 1'b1;
				xpd_seen_ff <= 1'b1;
				xpd_h_ff    <= mk_h;
				xpd_v_ff    <= mk_v;
			end
			`HFR_MK_SOF: begin
				st_ff       <= ST_FRAME;
				in_frame_ff <= 1'b1;
				sof_seen_ff <= 1'b1;
				xpd_seen_ff <= 1'b0;
				diff_ff     <= mk_diff;
				dct_ff      <= mk_dct;
				pt_ff       <= mk_pt;
				lvl_ff      <= mk_dct && !mk_diff; // R14 R21
				dcp_ff      <= mk_dct && !mk_diff; // R14 R21
				psz_ff      <= !mk_dct && mk_diff; // R15
				pta_ff      <= !mk_dct && mk_diff && (mk_pt != 4'h0); // R23
				cat_ff      <= mk_diff ? `HFR_CAT_DIFF : `HFR_CAT_BASE; // R16
				if (mk_diff) begin
					if (!hier_ff || !nd_done_ff[mk_comp])
						err_ff[`HFR_ERR_FIRST] <= 1'b1; // R2
					if (ll_done_ff[mk_comp] || (first_ll_ff && mk_dct))
						err_ff[`HFR_ERR_MODE] <= 1'b1; // R6 R7
					if (!mk_dct)
						ll_done_ff[mk_comp] <= 1'b1; // R6
					if (enc_mode) begin
						// Encoder announces the segment ahead of the frame
						up_h_ff     <= mk_h;
						up_v_ff     <= mk_v;
						xpd_emit_ff <= (mk_h | mk_v) && !xpd_seen_ff; // R3 R4
					end else begin
						up_h_ff <= xpd_seen_ff && xpd_h_ff; // R19
						up_v_ff <= xpd_seen_ff && xpd_v_ff; // R19
					end
				end else begin
					if (nd_done_ff[mk_comp])
						err_ff[`HFR_ERR_FIRST] <= 1'b1; // R2
					nd_done_ff[mk_comp] <= 1'b1;
					first_set_ff        <= 1'b1;
					if (!first_set_ff)
						first_ll_ff <= !mk_dct;
					else if (first_ll_ff == mk_dct)
						err_ff[`HFR_ERR_MODE] <= 1'b1; // R7
					up_h_ff <= 1'b0;
					up_v_ff <= 1'b0;
				end
			end
			`HFR_MK_END: st_ff <= ST_IDLE; // R17
			default: ;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Horizontal stage: each input yields up to four outputs from a small queue
reg  [`HFR_SW-1:0] hq_ff [0:3];
reg  [2:0]         hn_ff;
reg  [1:0]         hi_ff;
reg  [`HFR_SW-1:0] hp_ff;
reg                hhave_ff;
reg                hlc_ff;
reg                hlr_ff;
reg                in_rdy_ff;
reg  [2:0]         nxt_hn;
reg  [1:0]         nxt_hi;
reg                h_ordy;

wire               in_acc = in_valid & in_rdy_ff;
wire [`HFR_SW:0]   hsum   = {1'b0, hp_ff} + {1'b0, in_data};
wire [`HFR_SW-1:0] havg   = hsum[`HFR_SW:1]; // R9
wire               h_ov   = (hn_ff != 3'h0);
wire [`HFR_SW-1:0] h_od   = hq_ff[hi_ff];
wire               h_end  = ({1'b0, hi_ff} == hn_ff - 3'h1);
wire               h_olc  = hlc_ff & h_end;
wire               h_take = h_ov & h_ordy;

always @* begin
	nxt_hn = hn_ff;
	nxt_hi = hi_ff;
	if (h_take) begin
		if (h_end) begin
			nxt_hn = 3'h0;
			nxt_hi = 2'h0;
		end else begin
			nxt_hi = hi_ff + 2'h1;
		end
	end
	if (in_acc) begin
		if (!up_h_ff)
			nxt_hn = 3'h1;
		else
			nxt_hn = (hhave_ff ? 3'h2 : 3'h0) + (in_last_col ? 3'h2 : 3'h0); // R12
	end
end

always @(posedge clock) begin
	if (clr) begin
		hn_ff     <= 3'h0;
		hi_ff     <= 2'h0;
		hhave_ff  <= 1'b0;
		hlc_ff    <= 1'b0;
		hlr_ff    <= 1'b0;
		in_rdy_ff <= 1'b0;
	end else begin
		hn_ff     <= nxt_hn;
		hi_ff     <= nxt_hi;
		// Registered ready trades half throughput for a flop-driven port
		in_rdy_ff <= (nxt_hn == 3'h0);
		if (in_acc) begin
			hlc_ff <= in_last_col;
			hlr_ff <= in_last_row;
			if (!up_h_ff) begin
				hq_ff[0] <= in_data;
			end else begin
				hp_ff    <= in_data;
				hhave_ff <= !in_last_col;
				if (hhave_ff) begin
					hq_ff[0] <= hp_ff;
					hq_ff[1] <= havg; // R8
				end
				// Left column passes straight; right edge repeats itself
				if (in_last_col && hhave_ff) begin
					hq_ff[2] <= in_data; // R11
					hq_ff[3] <= in_data; // R11
				end else if (in_last_col) begin
					hq_ff[0] <= in_data; // R10
					hq_ff[1] <= in_data; // R11
				end
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Vertical stage on the horizontal result, two line stores in flip-flops
reg  [`HFR_SW-1:0] vb_ff [0:(2<<LAW)-1];
reg  [1:0]         vs_ff;
reg                vsel_ff;
reg  [LAW-1:0]     vk_ff;
reg  [LAW-1:0]     vlen_ff;
reg                vlr_ff;
reg                v_ov;
reg  [`HFR_SW-1:0] v_od;
wire               v_rdy;

wire [`HFR_SW-1:0] va     = vb_ff[{vsel_ff, vk_ff}];
wire [`HFR_SW-1:0] vnew   = vb_ff[{~vsel_ff, vk_ff}];
wire [`HFR_SW:0]   vsum   = {1'b0, va} + {1'b0, h_od};
wire               v_take = v_ov & v_rdy;
wire               v_last = (vk_ff == vlen_ff);

always @* begin
	v_ov   = h_ov;
	v_od   = h_od; // R13
	h_ordy = v_rdy;
	case (vs_ff)
	VS_INTERP: v_od = vsum[`HFR_SW:1]; // R8 R9
	VS_REPLAY: begin
		v_ov   = 1'b1;
		v_od   = vnew;
		h_ordy = 1'b0;
	end
	VS_DUP: begin
		v_ov   = 1'b1;
		v_od   = va; // R11
		h_ordy = 1'b0;
	end
	default: ;
	endcase
end

always @(posedge clock) begin
	if (clr) begin
		vs_ff   <= VS_FIRST;
		vsel_ff <= 1'b0;
		vk_ff   <= {LAW{1'b0}};
		vlen_ff <= {LAW{1'b0}};
		vlr_ff  <= 1'b0;
	end else if (v_take) begin
		// Counting only while expanding holds the column index at zero while lines pass through
		if (up_v_ff)
			vk_ff <= vk_ff + {{(LAW-1){1'b0}}, 1'b1};
		case (vs_ff)
		VS_FIRST: begin
			// Top line goes out unchanged while it is stored
			if (up_v_ff) begin
				vb_ff[{vsel_ff, vk_ff}] <= h_od; // R10
				if (h_olc) begin
					vlen_ff <= vk_ff;
					vk_ff   <= {LAW{1'b0}};
					vs_ff   <= hlr_ff ? VS_DUP : VS_INTERP; // R11
				end
			end
		end
		VS_INTERP: begin
			vb_ff[{~vsel_ff, vk_ff}] <= h_od;
			if (h_olc) begin
				vk_ff  <= {LAW{1'b0}};
				vlr_ff <= hlr_ff;
				vs_ff  <= VS_REPLAY; // R12
			end
		end
		VS_REPLAY: begin
			if (v_last) begin
				vk_ff   <= {LAW{1'b0}};
				vsel_ff <= ~vsel_ff;
				vs_ff   <= vlr_ff ? VS_DUP : VS_INTERP; // R11
			end
		end
		default: begin
			if (v_last) begin
				vk_ff <= {LAW{1'b0}};
				vs_ff <= VS_FIRST;
			end
		end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Join reference with operand, reconstruct or difference, two-entry buffer
reg                oh_v_ff;
reg  [`HFR_SW-1:0] oh_d_ff;
reg                op_rdy_ff;
reg                o_v_ff;
reg  [`HFR_SW-1:0] o_d_ff;
reg                s_v_ff;
reg  [`HFR_SW-1:0] s_d_ff;
reg  [`HFR_SW-1:0] res;

wire               op_acc = op_valid & op_rdy_ff;
wire               fire   = oh_v_ff & !s_v_ff & (!diff_ff | v_ov);
assign             v_rdy  = fire & diff_ff;
wire               pop    = o_v_ff & out_ready;
wire [`HFR_SW-1:0] dsh    = pta_ff ? (oh_d_ff << pt_ff) : oh_d_ff; // R23
wire [`HFR_SW:0]   rsum   = {1'b0, v_od} + {1'b0, dsh};
wire [`HFR_SW:0]   rdif   = {1'b0, oh_d_ff} - {1'b0, v_od};
wire               nxt_oh = (oh_v_ff & !fire) | op_acc;

always @* begin
	res = oh_d_ff;
	if (diff_ff)
		res = enc_mode ? rdif[`HFR_SW-1:0] : rsum[`HFR_SW-1:0]; // R5 R20
end

always @(posedge clock) begin
	if (clr) begin
		oh_v_ff   <= 1'b0;
		op_rdy_ff <= 1'b0;
		o_v_ff    <= 1'b0;
		o_d_ff    <= 16'h0000;
		s_v_ff    <= 1'b0;
	end else begin
		oh_v_ff   <= nxt_oh;
		op_rdy_ff <= !nxt_oh;
		if (op_acc)
			oh_d_ff <= op_data;
		// Second entry absorbs one word when the sink stalls
		if (pop) begin
			if (s_v_ff) begin
				o_d_ff <= s_d_ff;
				s_v_ff <= 1'b0;
			end else begin
				o_v_ff <= fire;
				o_d_ff <= res; // R22
			end
		end else if (!o_v_ff) begin
			o_v_ff <= fire;
			o_d_ff <= res; // R22
		end else if (fire) begin
			s_v_ff <= 1'b1;
			s_d_ff <= res;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Outputs
assign in_ready       = in_rdy_ff;
assign op_ready       = op_rdy_ff;
assign out_valid      = o_v_ff;
assign out_data       = o_d_ff;
assign hier_path      = hier_ff;
assign in_frame       = in_frame_ff;
assign diff_frame     = diff_ff;
assign level_shift_en = lvl_ff;
assign dc_pred_en     = dcp_ff;
assign pred_sel_zero  = psz_ff;
assign pt_apply       = pta_ff;
assign ac_cat_max     = cat_ff;
assign up_h           = up_h_ff;
assign up_v           = up_v_ff;
assign expand_emit    = xpd_emit_ff;
assign err            = err_ff;

endmodule

//--- sim/hfr_top_asserts.sv
// Checker of marker sequencing, frame modes and output buffering
`timescale 1ns/1ns
`include "hfr_defines.vh"
module hfr_top_asserts #(
	parameter CW = 2
) (
	input logic                  clock,
	input logic                  rst,
	input logic                  enc_mode,
	input logic                  mk_valid,
	input logic [`HFR_MK_W-1:0]  mk_type,
	input logic [CW-1:0]         mk_comp,
	input logic                  mk_diff,
	input logic                  mk_dct,
	input logic                  mk_h,
	input logic                  mk_v,
	input logic                  out_valid,
	input logic [`HFR_SW-1:0]    out_data,
	input logic                  out_ready,
	input logic                  hier_path,
	input logic                  in_frame,
	input logic                  diff_frame,
	input logic                  level_shift_en,
	input logic                  dc_pred_en,
	input logic                  pred_sel_zero,
	input logic [3:0]            ac_cat_max,
	input logic                  up_h,
	input logic                  expand_emit,
	input logic [`HFR_ERR_W-1:0] err
);
	logic               go_ff;
	logic               xs_ff;
	logic               xh_ff;
	logic               ss_ff;
	logic [(1<<CW)-1:0] nd_ff;
	wire take = go_ff && !in_frame && mk_valid;
	wire soi  = mk_valid && mk_type == `HFR_MK_SOI;
	wire sof  = take && mk_type == `HFR_MK_SOF;
	wire xp   = take && mk_type == `HFR_MK_EXPAND;
	wire esof = sof && enc_mode;
	////////////////////////////////////////////////////////////////////////////////
	// Mirrors parser state; markers other than soi are ignored inside a frame, so apart from soi only take counts
	always @(posedge clock) begin
		if (rst || soi) begin
			go_ff <= !rst;
			xs_ff <= 1'b0;
			xh_ff <= 1'b0;
			ss_ff <= 1'b0;
			nd_ff <= '0;
		end else begin
			if (take && mk_type == `HFR_MK_END)
				go_ff <= 1'b0;
			if (xp) begin
				xs_ff <= 1'b1;
				xh_ff <= mk_h;
			end else if (sof)
				xs_ff <= 1'b0;
			if (sof)
				ss_ff <= 1'b1;
			if (sof && !mk_diff)
				nd_ff[mk_comp] <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence sof_diff_s;
		sof && mk_diff;
	endsequence
	sequence expand_s;
		xp;
	endsequence
	frame_cat_a: assert property (sof |=> in_frame &&
		ac_cat_max == ($past(mk_diff) ? `HFR_CAT_DIFF : `HFR_CAT_BASE)) else $error("frame category wrong");
	dct_diff_a: assert property (sof_diff_s ##0 mk_dct |=>
		!level_shift_en && !dc_pred_en && diff_frame) else $error("differential dct mode wrong");
	ll_diff_a: assert property (sof_diff_s ##0 !mk_dct |=> pred_sel_zero) else $error("selector not zero");
	up_dir_a: assert property (sof_diff_s ##0 (xs_ff && !enc_mode) |=>
		up_h == $past(xh_ff)) else $error("upsample direction wrong");
	first_nd_a: assert property (sof_diff_s ##0 !nd_ff[mk_comp] |=>
		err[`HFR_ERR_FIRST]) else $error("missing nondiff not flagged");
	expand_twice_a: assert property (expand_s ##0 xs_ff |=> err[`HFR_ERR_TWICE])
		else $error("second expansion missed");
	expand_emit_a: assert property (esof && mk_diff && (mk_h || mk_v) && !xs_ff |=> expand_emit)
		else $error("no expansion request");
	emit_cause_a: assert property (expand_emit |-> $past(esof && mk_diff))
		else $error("stray expansion request");
	hier_flag_a: assert property (take && mk_type == `HFR_MK_DESC && !ss_ff |=>
		hier_path) else $error("hierarchical flag not set");
	start_clr_a: assert property (soi |=> !hier_path && err == '0 && !up_h) else $error("image start left state");
	stall_hold_a: assert property (out_valid && !out_ready |=>
		out_valid && $stable(out_data)) else $error("output lost on stall");
endmodule
bind hfr_top hfr_top_asserts #(.CW(CW)) i_chk (.clock, .rst, .enc_mode, .mk_valid, .mk_type, .mk_comp,
	.mk_diff, .mk_dct, .mk_h, .mk_v, .out_valid, .out_data, .out_ready, .hier_path, .in_frame, .diff_frame,
	.level_shift_en, .dc_pred_en, .pred_sel_zero, .ac_cat_max, .up_h, .expand_emit, .err);

//--- sim/hfr_far_model.sv
// Far-side model: reference and operand sources, stalling output sink
`timescale 1ns/1ns
module hfr_far_model (
	input  logic        clock,
	input  logic        in_ready,
	input  logic        op_ready,
	input  logic        out_valid,
	input  logic [15:0] out_data,
	output logic        in_valid,
	output logic [15:0] in_data,
	output logic        in_last_col,
	output logic        in_last_row,
	output logic        op_valid,
	output logic [15:0] op_data,
	output logic        out_ready
);
	logic [17:0] rq[$];
	logic [15:0] oq[$];
	logic [15:0] got[$];
	integer      sd = 32'h81a8;
	initial begin
		{in_valid, in_data, in_last_col, in_last_row, op_valid, op_data, out_ready} = '0;
	end
	// Words advance only on a taken handshake, so each stays put until accepted
	always @(posedge clock) begin
		if (in_valid && in_ready)
			void'(rq.pop_front());
		if (op_valid && op_ready)
			void'(oq.pop_front());
		if (out_valid && out_ready)
			got.push_back(out_data);
		#1;
		in_valid = rq.size() > 0;
		// Released lines toggle so a stale word never passes for a fresh one
		{in_last_row, in_last_col, in_data} = in_valid ? rq[0] : ~{in_last_row, in_last_col, in_data};
		op_valid = oq.size() > 0;
		op_data = op_valid ? oq[0] : ~op_data;
		out_ready = ($random(sd) & 3) != 0;
	end
endmodule

//--- sim/testbench.sv
// Self-checking bench of the hierarchical frame reconstruction block
`timescale 1ns/1ns
`include "hfr_defines.vh"
module testbench;
	logic        clock, rst, enc_mode, mk_valid, mk_diff, mk_dct, mk_h, mk_v, frame_done;
	logic [2:0]  mk_type;
	logic [1:0]  mk_comp;
	logic [3:0]  mk_pt, ac_cat_max, err;
	logic [15:0] in_data, op_data, out_data;
	logic        in_valid, in_last_col, in_last_row, in_ready, op_valid, op_ready, out_valid, out_ready;
	logic        hier_path, in_frame, diff_frame, level_shift_en, dc_pred_en, pred_sel_zero, pt_apply;
	logic        up_h, up_v, expand_emit;
	integer      seed = 32'h81a8;
	int          err_total, n_compared, gw, gh;
	logic [15:0] rf[0:7][0:7];
	logic [15:0] ov[0:255];

	hfr_top i_dut (.clock, .rst, .enc_mode, .mk_valid, .mk_type, .mk_comp, .mk_diff, .mk_dct, .mk_h, .mk_v,
		.mk_pt, .frame_done, .in_valid, .in_data, .in_last_col, .in_last_row, .in_ready, .op_valid, .op_data,
		.op_ready, .out_valid, .out_data, .out_ready, .hier_path, .in_frame, .diff_frame, .level_shift_en,
		.dc_pred_en, .pred_sel_zero, .pt_apply, .ac_cat_max, .up_h, .up_v, .expand_emit, .err);
	hfr_far_model i_far (.clock, .in_ready, .op_ready, .out_valid, .out_data, .in_valid, .in_data,
		.in_last_col, .in_last_row, .op_valid, .op_data, .out_ready);

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////////////////
	task conclude;
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(string nm, logic [15:0] ex, logic [15:0] got);
		n_compared++;
		if (got !== ex) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// Leaves mk_valid high so markers can follow back to back
	task mk(logic [2:0] t, logic [1:0] c = 0, logic d = 0, logic x = 1, logic h = 0, logic v = 0,
		logic [3:0] p = 0);
		{mk_type, mk_comp, mk_diff, mk_dct, mk_h, mk_v, mk_pt} = {t, c, d, x, h, v, p};
		mk_valid = 1'b1;
		@(posedge clock);
		#1;
	endtask
	task nomk;
		mk_valid = 1'b0;
		@(posedge clock);
		#1;
	endtask
	task fd;
		frame_done = 1'b1;
		@(posedge clock);
		#1;
		frame_done = 1'b0;
		@(posedge clock);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	function logic [15:0] av(logic [15:0] a, logic [15:0] b);
		logic [16:0] s;
		s = a + b;
		return s[16:1];
	endfunction
	function logic [15:0] hx(int r, int c, bit h);
		if (!h)
			return rf[r][c];
		if (c % 2 == 0)
			return rf[r][c/2];
		return av(rf[r][c/2], rf[r][c/2+1 < gw ? c/2+1 : gw-1]);
	endfunction
	// Vertical pass works on the horizontally expanded rows
	function logic [15:0] upref(int r, int c, bit h, bit v);
		if (!v)
			return hx(r, c, h);
		if (r % 2 == 0)
			return hx(r/2, c, h);
		return av(hx(r/2, c, h), hx(r/2+1 < gh ? r/2+1 : gh-1, c, h));
	endfunction
	task frame(bit d, bit h, bit v, bit en, int p);
		int r, c, k, ow, oh, t;
		logic [15:0] e;
		gw = 2 + ($random(seed) & 3);
		gh = 2 + ($random(seed) & 1);
		ow = h ? 2 * gw : gw;
		oh = v ? 2 * gh : gh;
		i_far.got.delete();
		for (r = 0; r < gh; r++)
			for (c = 0; c < gw; c++) begin
				rf[r][c] = $random(seed);
				if (d)
					i_far.rq.push_back({r == gh - 1, c == gw - 1, rf[r][c]});
			end
		for (k = 0; k < ow * oh; k++) begin
			ov[k] = $random(seed);
			i_far.oq.push_back(ov[k]);
		end
		for (t = 0; t < 4000 && i_far.got.size() < ow * oh; t++)
			@(posedge clock);
		#1;
		chk("count", 16'(ow * oh), 16'(i_far.got.size()));
		for (k = 0; k < ow * oh; k++) begin
			e = upref(k / ow, k % ow, h, v);
			e = !d ? ov[k] : en ? ov[k] - e : e + (ov[k] << p);
			chk("sample", e, i_far.got[k]);
		end
		fd;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (50000) @(posedge clock);
		err_total++;
		conclude;
	end
	initial begin
		int i;
		{enc_mode, mk_valid, mk_type, mk_comp, mk_diff, mk_dct, mk_h, mk_v, mk_pt, frame_done} = '0;
		rst = 1'b1;
		repeat (20) @(posedge clock);
		#1;
		rst = 1'b0;
		chk("cat", 16'(`HFR_CAT_BASE), 16'(ac_cat_max));
		chk("flags", 16'h0, 16'({hier_path, in_frame, up_h, up_v, err}));
		mk(`HFR_MK_SOI);
		mk(`HFR_MK_DESC);
		nomk;
		chk("hier", 16'h1, 16'(hier_path));
		mk(`HFR_MK_SOF);
		nomk;
		chk("ndmod", 16'hd, 16'({level_shift_en, dc_pred_en, diff_frame, in_frame}));
		frame(0, 0, 0, 0, 0);
		for (i = 0; i < 3; i++) begin
			mk(`HFR_MK_EXPAND, 0, 0, 0, i != 1, i != 0);
			mk(`HFR_MK_SOF, 0, 1, i < 2, i != 1, i != 0, 4'(2 * (i / 2)));
			nomk;
			chk("cat", 16'hf, 16'(ac_cat_max));
			chk("updir", 16'({i != 1, i != 0}), 16'({up_h, up_v}));
			if (i < 2)
				chk("dctmod", 16'h0, 16'({level_shift_en, dc_pred_en}));
			else
				chk("llmod", 16'h3, 16'({pred_sel_zero, pt_apply}));
			frame(1, i != 1, i != 0, 0, 2 * (i / 2));
		end
		chk("err", 16'h0, 16'(err));
		$display("decoder image done");
		mk(`HFR_MK_SOI);
		mk(`HFR_MK_EXPAND, 0, 0, 1, 1);
		mk(`HFR_MK_EXPAND, 0, 0, 1, 1);
		mk(`HFR_MK_SOF, 1, 1);
		nomk;
		chk("err", 16'h7, 16'(err));
		fd;
		mk(`HFR_MK_SOI);
		mk(`HFR_MK_DESC);
		mk(`HFR_MK_SOF, 0, 0, 0);
		nomk;
		fd;
		mk(`HFR_MK_SOF, 0, 1, 1);
		nomk;
		chk("err", 16'h8, 16'(err));
		fd;
		mk(`HFR_MK_DESC);
		nomk;
		chk("err", 16'h9, 16'(err));
		$display("error images done");
		enc_mode = 1'b1;
		mk(`HFR_MK_SOI);
		nomk;
		chk("clear", 16'h0, 16'({hier_path, err}));
		mk(`HFR_MK_DESC);
		mk(`HFR_MK_SOF);
		nomk;
		frame(0, 0, 0, 1, 0);
		mk(`HFR_MK_SOF, 0, 1, 1, 1, 0);
		chk("emit", 16'h1, 16'(expand_emit));
		nomk;
		frame(1, 1, 0, 1, 0);
		mk(`HFR_MK_OTHER);
		mk(`HFR_MK_END);
		mk(`HFR_MK_SOF, 1);
		nomk;
		chk("ended", 16'h0, 16'({in_frame, err}));
		$display("encoder image done");
		conclude;
	end
endmodule
